// ---- verilog/kms_consts.svh ----
// constants of the key matrix scanner: sizes, timing, offsets, fields, resets
`ifndef KMS_CONSTS_SVH
`define KMS_CONSTS_SVH
`define KMS_CLK_HZ 20000000
`define KMS_SCAN_HZ 128000
`define KMS_TICK_DIV (`KMS_CLK_HZ / `KMS_SCAN_HZ)
`define KMS_ROWS 8
`define KMS_COLS 20
`define KMS_BUF_DEPTH 16
`define KMS_NMOD 8
`define KMS_COL_MAX 5'd19
`define KMS_COLS_IDLE 20'hfffff
`define KMS_COL0_LOW 20'hffffe
`define KMS_OFF_CTRL 8'h00
`define KMS_OFF_STATUS 8'h04
`define KMS_OFF_KEYDATA 8'h08
`define KMS_OFF_MODA 8'h0c
`define KMS_OFF_MODB 8'h10
`define KMS_CTRL_EN_BIT 0
`define KMS_CTRL_COL_LSB 8
`define KMS_CTRL_ROW_LSB 16
`define KMS_CTRL_RST 32'h00071301
`define KMS_MOD_RST 64'hffffffffffffffff
`define KMS_RESP_OKAY 2'b00
`define KMS_RESP_SLVERR 2'b10
`endif

// ---- verilog/kms_pkg.sv ----
// types of the key matrix scanner
package kms_pkg;
   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_scan = 3'b010,
      st_end = 3'b100
   } kms_state_t;
   typedef struct packed {
      logic [2:0] row_last;
      logic [4:0] col_last;
      logic en;
   } kms_ctrl_t;
endpackage

// ---- verilog/kms_top.sv ----
// key matrix scanner with key-code buffer behind an axi4-lite slave
// What this block does
// - scan up to 8 rows by 20 columns
// - column count programmable one to twenty
// - row count programmable one to eight
// - sixteen-byte hardware key-code buffer
// - scan steps at 128 kHz rate
// - any key count; ghost keys locked out
// - codes kept until read; overflow drops new codes
// - rows debounced and glitch filtered
// - idle after reset, all columns high
// - row change in idle requests clock, scans
// - idle clears row-hit and key index
// - row counter wraps, then column advances
// - both counters terminal ends the pass
// - key index advances every position
// - modifiers flagged, other codes buffered
// - multi-hit column ORed into row-hit
// - hit on row-hit row sets ghost
// - pass end: rescan if keys, else idle
`timescale 1ns/1ps
`default_nettype none
`include "kms_consts.svh"
module kms_top (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] row_in,
   output logic [19:0] col_out,
   output logic clk_req
);
   import kms_pkg::*;

   kms_state_t st_q;
   kms_ctrl_t ctrl_q;
   logic [63:0] mod_code_q;
   logic [7:0] row_s1_q, row_s2_q, row_h1_q, row_h2_q, row_f_q, row_p_q;
   logic [7:0] div_q, row_hit_q, key_idx_q, mod_live_q;
   logic tick_q, clk_req_q, any_q, ghost_q, ovf_q;
   logic [2:0] row_cnt_q;
   logic [4:0] col_cnt_q, cnt_q;
   logic [19:0] col_out_q;
   logic [159:0] key_state_q, raw_prev_q;
   logic [7:0] mem_q [`KMS_BUF_DEPTH];
   logic [3:0] wp_q, rp_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q, rdata_q;
   logic [3:0] w_strb_q;
   logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;

   assign col_out = col_out_q;
   assign clk_req = clk_req_q;
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ------------------------------------------------------------
   // row input conditioning
   // ------------------------------------------------------------
   // two-stage synchroniser; stage one feeds stage two only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         row_s1_q <= 8'hff;
         row_s2_q <= 8'hff;
      end else begin
         row_s1_q <= row_in;
         row_s2_q <= row_s1_q;
      end
   end

   // glitch filter: a row only moves after three equal samples
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         row_h1_q <= 8'hff;
         row_h2_q <= 8'hff;
         row_f_q <= 8'hff;
         row_p_q <= 8'hff;
      end else begin
         row_h1_q <= row_s2_q;
         row_h2_q <= row_h1_q;
         row_p_q <= row_f_q;
         for (int i = 0; i < `KMS_ROWS; i++) begin
            if (row_s2_q[i] == row_h1_q[i] && row_h1_q[i] == row_h2_q[i]) begin
               row_f_q[i] <= row_s2_q[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // scan rate divider
   // ------------------------------------------------------------
   // runs only while the slow clock is requested, as a gated clock would
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= 8'h00;
         tick_q <= 1'b0;
      end else if (!clk_req_q) begin
         div_q <= 8'h00;
         tick_q <= 1'b0;
      end else if (div_q == 8'(`KMS_TICK_DIV - 1)) begin
         div_q <= 8'h00;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 8'h01;
         tick_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // position decode
   // ------------------------------------------------------------
   logic [7:0] row_mask, col_hits, mod_match;
   logic [3:0] nhits;
   logic multi, hit, ghost_now, scan_tick, press, release_k, push, full, pop, rd_stat;

   // pressed keys read low; rows beyond the programmed count are masked
   always_comb begin
      row_mask = 8'h00;
      nhits = 4'h0;
      mod_match = 8'h00;
      for (int i = 0; i < `KMS_ROWS; i++) begin
         row_mask[i] = (3'(i) <= ctrl_q.row_last);
      end
      col_hits = ~row_f_q & row_mask;
      for (int i = 0; i < `KMS_ROWS; i++) begin
         nhits = nhits + {3'b000, col_hits[i]};
      end
      for (int m = 0; m < `KMS_NMOD; m++) begin
         mod_match[m] = (mod_code_q[8*m +: 8] == key_idx_q);
      end
      multi = (nhits >= 4'h2);
      hit = col_hits[row_cnt_q];
      ghost_now = hit && row_hit_q[row_cnt_q];
   end

   assign scan_tick = (st_q == st_scan) && tick_q;
   // a press needs two passes in agreement, which debounces the switch
   assign press = scan_tick && hit && raw_prev_q[key_idx_q] && !key_state_q[key_idx_q]
      && !ghost_now;
   assign release_k = scan_tick && !hit && !raw_prev_q[key_idx_q];
   assign push = press && (mod_match == 8'h00);
   assign full = (cnt_q == 5'(`KMS_BUF_DEPTH));

   // ------------------------------------------------------------
   // scan state machine
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= st_idle;
         col_out_q <= `KMS_COLS_IDLE;
         clk_req_q <= 1'b0;
         row_cnt_q <= 3'd0;
         col_cnt_q <= 5'd0;
         row_hit_q <= 8'h00;
         key_idx_q <= 8'h00;
         any_q <= 1'b0;
      end else begin
         case (st_q)
            st_idle: begin
               col_out_q <= `KMS_COLS_IDLE;
               row_hit_q <= 8'h00;
               key_idx_q <= 8'h00;
               row_cnt_q <= 3'd0;
               col_cnt_q <= 5'd0;
               any_q <= 1'b0;
               // a held low row also wakes, so a key kept down is not missed
               if (ctrl_q.en && (row_f_q != row_p_q || row_f_q != 8'hff)) begin
                  clk_req_q <= 1'b1;
                  col_out_q <= `KMS_COL0_LOW;
                  st_q <= st_scan;
               end
            end
            st_scan: begin
               if (tick_q) begin
                  key_idx_q <= key_idx_q + 8'h01;
                  if (hit) begin
                     any_q <= 1'b1;
                  end
                  if (row_cnt_q >= ctrl_q.row_last) begin
                     row_cnt_q <= 3'd0;
                     if (multi) begin
                        row_hit_q <= row_hit_q | col_hits;
                     end
                     if (col_cnt_q >= ctrl_q.col_last) begin
                        st_q <= st_end;
                        col_out_q <= `KMS_COLS_IDLE;
                     end else begin
                        col_cnt_q <= col_cnt_q + 5'd1;
                        col_out_q <= ~(20'h00001 << (col_cnt_q + 5'd1));
                     end
                  end else begin
                     row_cnt_q <= row_cnt_q + 3'd1;
                  end
               end
            end
            st_end: begin
               row_cnt_q <= 3'd0;
               col_cnt_q <= 5'd0;
               key_idx_q <= 8'h00;
               row_hit_q <= 8'h00;
               any_q <= 1'b0;
               if (any_q) begin
                  st_q <= st_scan;
                  col_out_q <= `KMS_COL0_LOW;
               end else begin
                  st_q <= st_idle;
                  clk_req_q <= 1'b0;
               end
            end
            default: begin
               st_q <= st_idle;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // key state, modifiers and flags
   // ------------------------------------------------------------
   // ghost keys never change state, so both keys of the pattern stay out
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         key_state_q <= '0;
         raw_prev_q <= '0;
         mod_live_q <= 8'h00;
      end else if (st_q == st_idle) begin
         key_state_q <= '0;
         raw_prev_q <= '0;
         mod_live_q <= 8'h00;
      end else if (scan_tick) begin
         raw_prev_q[key_idx_q] <= hit;
         if (press) begin
            key_state_q[key_idx_q] <= 1'b1;
            mod_live_q <= mod_live_q | mod_match;
         end
         if (release_k) begin
            key_state_q[key_idx_q] <= 1'b0;
            mod_live_q <= mod_live_q & ~mod_match;
         end
      end
   end

   // sticky flags: a new event wins over the clear by a status read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ghost_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         ghost_q <= (ghost_q && !rd_stat) || (scan_tick && ghost_now);
         ovf_q <= (ovf_q && !rd_stat) || (push && full);
      end
   end

   // ------------------------------------------------------------
   // key-code buffer
   // ------------------------------------------------------------
   // codes stay until popped; a full buffer keeps the oldest ones
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wp_q <= 4'h0;
         rp_q <= 4'h0;
         cnt_q <= 5'd0;
         for (int i = 0; i < `KMS_BUF_DEPTH; i++) begin
            mem_q[i] <= 8'h00;
         end
      end else begin
         if (push && !full) begin
            mem_q[wp_q] <= key_idx_q;
            wp_q <= wp_q + 4'h1;
         end
         if (pop) begin
            rp_q <= rp_q + 4'h1;
         end
         cnt_q <= cnt_q + {4'h0, push && !full} - {4'h0, pop};
      end
   end

   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   logic do_wr, wr_map;
   logic [31:0] ctrl_word, wr_val, rd_word;
   logic [7:0] ar_a, aw_a;
   logic rd_map;

   assign do_wr = aw_held_q && w_held_q && !bvalid_q;
   assign ar_a = {s_axi_araddr[7:2], 2'b00};
   assign aw_a = {aw_addr_q[7:2], 2'b00};
   assign ctrl_word = {13'h0000, ctrl_q.row_last, 3'b000, ctrl_q.col_last, 7'h00, ctrl_q.en};
   assign rd_stat = s_axi_arvalid && arready_q && (ar_a == `KMS_OFF_STATUS);
   assign pop = s_axi_arvalid && arready_q && (ar_a == `KMS_OFF_KEYDATA) && (cnt_q != 5'd0);
   assign wr_map = (aw_a == `KMS_OFF_CTRL) || (aw_a == `KMS_OFF_STATUS)
      || (aw_a == `KMS_OFF_KEYDATA) || (aw_a == `KMS_OFF_MODA) || (aw_a == `KMS_OFF_MODB);

   // byte-lane merge of the write data into the addressed word
   always_comb begin
      case (aw_a)
         `KMS_OFF_CTRL: wr_val = ctrl_word;
         `KMS_OFF_MODA: wr_val = mod_code_q[31:0];
         `KMS_OFF_MODB: wr_val = mod_code_q[63:32];
         default: wr_val = 32'h00000000;
      endcase
      for (int b = 0; b < 4; b++) begin
         if (w_strb_q[b]) begin
            wr_val[8*b +: 8] = w_data_q[8*b +: 8];
         end
      end
   end

   // read mux; status carries everything software polls for
   always_comb begin
      rd_map = 1'b1;
      case (ar_a)
         `KMS_OFF_CTRL: rd_word = ctrl_word;
         `KMS_OFF_STATUS: rd_word = {16'h0000, mod_live_q, clk_req_q, ovf_q, ghost_q, cnt_q};
         `KMS_OFF_KEYDATA: rd_word = {23'h000000, cnt_q != 5'd0, mem_q[rp_q]};
         `KMS_OFF_MODA: rd_word = mod_code_q[31:0];
         `KMS_OFF_MODB: rd_word = mod_code_q[63:32];
         default: begin
            rd_word = 32'h00000000;
            rd_map = 1'b0;
         end
      endcase
   end

   // write address and data are held separately, taken in either order
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `KMS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            awready_q <= 1'b0;
         end else if (!aw_held_q && !bvalid_q) begin
            awready_q <= 1'b1;
         end
         if (s_axi_wvalid && wready_q) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            wready_q <= 1'b0;
         end else if (!w_held_q && !bvalid_q) begin
            wready_q <= 1'b1;
         end
         if (do_wr) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_map ? `KMS_RESP_OKAY : `KMS_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // a literal cannot be part-selected, so the reset word gets a name first
   localparam logic [31:0] ctrl_rst_c = `KMS_CTRL_RST;

   // control registers; column count saturates at the matrix width
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= kms_ctrl_t'({ctrl_rst_c[18:16], ctrl_rst_c[12:8], ctrl_rst_c[0]});
         mod_code_q <= `KMS_MOD_RST;
      end else if (do_wr) begin
         case (aw_a)
            `KMS_OFF_CTRL: begin
               ctrl_q.en <= wr_val[`KMS_CTRL_EN_BIT];
               ctrl_q.row_last <= wr_val[`KMS_CTRL_ROW_LSB +: 3];
               ctrl_q.col_last <= (wr_val[`KMS_CTRL_COL_LSB +: 5] > `KMS_COL_MAX) ?
                  `KMS_COL_MAX : wr_val[`KMS_CTRL_COL_LSB +: 5];
            end
            `KMS_OFF_MODA: mod_code_q[31:0] <= wr_val;
            `KMS_OFF_MODB: mod_code_q[63:32] <= wr_val;
            default: mod_code_q <= mod_code_q;
         endcase
      end
   end

   // read channel answers one cycle after the address is taken
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `KMS_RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_map ? `KMS_RESP_OKAY : `KMS_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_last_pos;
      scan_tick && row_cnt_q >= ctrl_q.row_last && col_cnt_q >= ctrl_q.col_last;
   endsequence
   sequence s_empty_end;
      st_q == st_end && !any_q;
   endsequence

   a_idle_cols_high: assert property (st_q == st_idle |-> col_out_q == 20'hfffff)
      else $error("columns not all high in idle");
   a_idle_clear: assert property (st_q == st_idle ##1 st_q == st_idle |->
      row_hit_q == 8'h00 && key_idx_q == 8'h00)
      else $error("row-hit or key index not cleared in idle");
   a_wake_scan: assert property (st_q == st_idle && ctrl_q.en && row_f_q != row_p_q |=>
      st_q == st_scan && clk_req_q)
      else $error("row change in idle did not start a scan");
   a_row_step: assert property (scan_tick && row_cnt_q < ctrl_q.row_last |=>
      row_cnt_q == $past(row_cnt_q) + 3'd1 && col_cnt_q == $past(col_cnt_q))
      else $error("row counter did not step");
   a_row_wrap: assert property (scan_tick && row_cnt_q >= ctrl_q.row_last
      && col_cnt_q < ctrl_q.col_last |=>
      row_cnt_q == 3'd0 && col_cnt_q == $past(col_cnt_q) + 5'd1)
      else $error("row wrap did not advance the column");
   a_pass_end: assert property (s_last_pos |=> st_q == st_end ##1 st_q != st_end)
      else $error("pass end not reached");
   a_end_idle: assert property (s_empty_end |=> st_q == st_idle && !clk_req_q)
      else $error("empty pass did not return to idle");
   a_one_col_low: assert property (st_q == st_scan |-> $onehot(~col_out_q) && clk_req_q)
      else $error("not exactly one column low in scan");
   a_col_bound: assert property (col_cnt_q <= 5'd19 && ctrl_q.col_last <= 5'd19)
      else $error("column counter beyond matrix");
   a_buf_bound: assert property (cnt_q <= 5'd16)
      else $error("buffer count beyond depth");
   // a pop in the same cycle may free one slot while the new code is still dropped
   a_ovf_set: assert property (push && full |=> ovf_q && cnt_q == 5'd16 - {4'h0, $past(pop)})
      else $error("overflow not flagged");
   a_ghost_set: assert property (scan_tick && ghost_now |-> !push ##1 ghost_q)
      else $error("ghost not flagged");

endmodule
`default_nettype wire

// ---- sim/kms_matrix.sv ----
// passive key switch matrix model driving the scanner's row inputs
`timescale 1ns/1ps
`default_nettype none
`include "kms_consts.svh"
module kms_matrix (
   input wire logic [19:0] col_out,
   input wire logic [159:0] pressed,
   output logic [7:0] row_in
);
   logic [7:0] direct;
   logic [7:0] sneak;
   // a pressed key ties its row to its column; with every column released
   // the raw presses show, otherwise an idle scanner could never wake
   always_comb begin
      direct = 8'h00;
      sneak = 8'h00;
      for (int c = 0; c < 20; c++) begin
         for (int r = 0; r < 8; r++) begin
            if (pressed[c*8+r] && (!col_out[c] || col_out == `KMS_COLS_IDLE)) begin
               direct[r] = 1'b1;
            end
         end
      end
      // a column bridging a low row drags its other rows down: the ghost path
      for (int c = 0; c < 20; c++) begin
         if ((pressed[c*8 +: 8] & direct) != 8'h00 && col_out != `KMS_COLS_IDLE) begin
            sneak = sneak | pressed[c*8 +: 8];
         end
      end
      row_in = ~(direct | sneak); // pull-ups hold released rows high
   end
endmodule
`default_nettype wire

// ---- sim/kms_top_tb.sv ----
// self-checking testbench of the key matrix scanner
`timescale 1ns/1ps
`default_nettype none
`include "kms_consts.svh"
module kms_top_tb;
   logic clk = 1'b0, arst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, row_in;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, s;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, clk_req;
   logic [1:0] bresp, rresp, resp;
   logic [19:0] col_out;
   logic [159:0] pressed = '0;
   int failures = 0, compares = 0;
   always #25 clk = ~clk;
   kms_top kms_top_i (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .row_in(row_in), .col_out(col_out), .clk_req(clk_req));
   kms_matrix kms_matrix_i (.col_out(col_out), .pressed(pressed), .row_in(row_in));
   // ------------------------------------------------------------
   // reporting
   // ------------------------------------------------------------
   task results;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task hang(input string what);
      failures++;
      $display("FAIL %s expected done seen timeout", what);
      results();
   endtask
   // ------------------------------------------------------------
   // axi4-lite master: one transfer at a time, waits on the answer
   // ------------------------------------------------------------
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
         if (++n > 200) hang("write");
      end
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
         if (++n > 200) hang("read");
      end
   endtask
   // software only polls the status word; the bound stands in for a watchdog
   task poll(input logic [31:0] mask, input logic [31:0] val);
      int n;
      for (n = 0; n < 3000; n++) begin
         rd(`KMS_OFF_STATUS, s, resp);
         if ((s & mask) === val) break;
      end
      if (n == 3000) hang("status poll");
   endtask
   task wait_req(input logic v);
      int n;
      for (n = 0; n < 20000; n++) begin
         @(posedge clk);
         if (clk_req === v) break;
      end
      if (n == 20000) hang("clock request");
   endtask
   task key_rd(input logic [31:0] exp);
      rd(`KMS_OFF_KEYDATA, s, resp);
      chk("keydata", exp, s);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk("idle columns", `KMS_COLS_IDLE, {12'h0, col_out});
      chk("idle request", 32'h0, {31'h0, clk_req});
      rd(`KMS_OFF_CTRL, s, resp);
      chk("ctrl reset", `KMS_CTRL_RST, s);
      rd(8'h40, s, resp);
      chk("unmapped read", {30'h0, `KMS_RESP_SLVERR}, {s[29:0], resp});
      wr(8'h40, 32'h1, resp);
      chk("unmapped write", {30'h0, `KMS_RESP_SLVERR}, {30'h0, resp});
      wr(`KMS_OFF_CTRL, 32'h00011f01, resp);
      rd(`KMS_OFF_CTRL, s, resp);
      chk("column saturate", 32'h00011301, s);
      // two rows by three columns; column 1 row 1 is position 3
      wr(`KMS_OFF_CTRL, 32'h00010201, resp);
      pressed[1*8+1] <= 1'b1;
      wait_req(1'b1);
      chk("first column low", `KMS_COL0_LOW, {12'h0, col_out});
      poll(32'h1f, 32'h1);
      chk("one active column", 32'h1, $countones(~col_out));
      key_rd(32'h103);
      pressed <= '0;
      wait_req(1'b0);
      chk("columns released", `KMS_COLS_IDLE, {12'h0, col_out});
      // rectangle of three keys: the column 1 hits close a ghost and stay locked
      pressed[0] <= 1'b1;
      pressed[1] <= 1'b1;
      pressed[8] <= 1'b1;
      poll(32'h1f, 32'h2);
      poll(32'h20, 32'h20);
      chk("ghost lockout", 32'h2, s & 32'h1f);
      key_rd(32'h100);
      key_rd(32'h101);
      key_rd(32'h000);
      pressed <= '0;
      wait_req(1'b0);
      // position 0 as modifier slot 0: flagged, never buffered
      wr(`KMS_OFF_MODA, 32'hffffff00, resp);
      pressed[0] <= 1'b1;
      poll(32'h100, 32'h100);
      key_rd(32'h000);
      pressed <= '0;
      wait_req(1'b0);
      rd(`KMS_OFF_STATUS, s, resp);
      chk("modifier cleared", 32'h0, s & 32'h100);
      wr(`KMS_OFF_MODA, 32'hffffffff, resp);
      // one-key matrix, seventeen separate presses overrun the sixteen slots
      wr(`KMS_OFF_CTRL, 32'h00000001, resp);
      for (int i = 0; i < 17; i++) begin
         pressed[0] <= 1'b1;
         if (i < 16) begin
            poll(32'h1f, i + 1);
         end else begin
            poll(32'h40, 32'h40);
            chk("full count", 32'h10, s & 32'h1f);
         end
         pressed <= '0;
         wait_req(1'b0);
      end
      rd(`KMS_OFF_STATUS, s, resp);
      chk("overflow read clears", 32'h0, s & 32'h40);
      for (int i = 0; i < 16; i++) key_rd(32'h100);
      key_rd(32'h000);
      results();
   end
endmodule
`default_nettype wire
